// ===== rfp_cfg.svh
// Constants of the regulator fault-protection block: offsets, fields,
// reset values and timing. Assumes a 125 MHz hclk.
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH

`define RFP_CLK_MHZ        125
// Least times round up to whole cycles
`define RFP_NS_TO_CYC(ns)  ((((ns) * `RFP_CLK_MHZ) + 999) / 1000)

`define RFP_OV_FILT_NS     1000
`define RFP_UV_FILT_NS     3000
`define RFP_UVLO_FILT_NS   3000
`define RFP_OCP_DELAY_NS   2000
`define RFP_QR_PULSE_NS    200
`define RFP_OV_FILT_CYC    `RFP_NS_TO_CYC(`RFP_OV_FILT_NS)
`define RFP_UV_FILT_CYC    `RFP_NS_TO_CYC(`RFP_UV_FILT_NS)
`define RFP_UVLO_FILT_CYC  `RFP_NS_TO_CYC(`RFP_UVLO_FILT_NS)
`define RFP_OCP_DELAY_CYC  `RFP_NS_TO_CYC(`RFP_OCP_DELAY_NS)
`define RFP_QR_PULSE_CYC   `RFP_NS_TO_CYC(`RFP_QR_PULSE_NS)

`define RFP_ADDR_CTRL      8'h00
`define RFP_ADDR_SPIKE     8'h04
`define RFP_ADDR_STATUS    8'h08
`define RFP_ADDR_THRESH    8'h0C

`define RFP_CTRL_QR_EN     0
`define RFP_CTRL_RESET     32'h0000_0001
`define RFP_SPIKE_RESET    12'hC00

`define RFP_ST_QR_BUSY     0
`define RFP_ST_OCP         1
`define RFP_ST_PER_PHASE_OVERCURRENT       2
`define RFP_ST_OVP         3
`define RFP_ST_UVP         4
`define RFP_ST_LOCKOUT     5
`define RFP_TH_QR_LSB      16

`define RFP_QR_TH_BASE     8'h18
`define RFP_QR_TH_STEP     8'h0C
`define RFP_RATIO_BASE     4'h8
`define RFP_RATIO_FRAC     3

`endif

// ===== rfp_pkg.sv
// Types and setting decoders of the regulator fault-protection block.
// Needs rfp_cfg.svh on the include path.
`include "rfp_cfg.svh"

package rfp_pkg;

    typedef enum logic [1:0] {
        QR_IDLE,
        QR_PULSE,
        QR_WAIT
    } rfp_qr_state_t;

    // Quick-response threshold code from the first platform setting
    function automatic logic [7:0] rfp_decode_qr(input logic [2:0] code);
        rfp_decode_qr = `RFP_QR_TH_BASE + (`RFP_QR_TH_STEP * {5'h00, code});
    endfunction

    // Per-phase setting ratio in eighths from the thermal platform setting
    function automatic logic [3:0] rfp_decode_ratio(input logic [2:0] code);
        rfp_decode_ratio = `RFP_RATIO_BASE + {1'b0, code};
    endfunction

endpackage

// ===== rfp_fault_filter.sv
// Persistence filter for one fault comparator.
// Condition must hold for CYCLES enabled clocks; any drop at an enabled clock restarts the count.
`timescale 1ns/1ps
`default_nettype none

module rfp_fault_filter #(
    parameter int CYCLES = 125
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic clk_en,
    input  wire logic cond,
    output var  logic expired
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES);

    logic [CW-1:0] count_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= '0;
        end else if (clk_en) begin
            if (!cond) begin
                count_q <= '0;
            end else if (count_q != LAST) begin
                count_q <= count_q + CW'(1);
            end
        end
    end

    assign expired = cond && (count_q == LAST);
endmodule

`default_nettype wire

// ===== rfp_ahb_regs.sv
// AHB-Lite slave holding control, spike limit and read-back registers.
// Zero wait states, always OKAY; unmapped reads return zero.
`timescale 1ns/1ps
`default_nettype none
`include "rfp_cfg.svh"

module rfp_ahb_regs
    import rfp_pkg::*;
#(
    parameter int CUR_W = 12
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             clk_en,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output var  logic [31:0]      hrdata,
    output var  logic             hreadyout,
    output var  logic             hresp,
    input  wire logic [5:0]       status,
    input  wire logic [CUR_W:0]   per_phase_overcurrent_th,
    input  wire logic [7:0]       qr_th,
    output var  logic             qr_enable,
    output var  logic [CUR_W-1:0] spike_limit
);
    logic [31:0]      ctrl_q;
    logic [CUR_W-1:0] spike_q;
    logic [31:0]      hrdata_q;
    logic             wr_pend_q;
    logic [7:0]       wr_addr_q;
    logic             addr_ok;
    logic [31:0]      rd_word;

    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        rd_word = 32'h0000_0000;
        case (haddr[7:0])
            `RFP_ADDR_CTRL:   rd_word = ctrl_q;
            `RFP_ADDR_SPIKE:  rd_word = {{(32-CUR_W){1'b0}}, spike_q};
            `RFP_ADDR_STATUS: rd_word = {26'h000_0000, status};
            `RFP_ADDR_THRESH: rd_word = {8'h00, qr_th, {(16-CUR_W-1){1'b0}}, per_phase_overcurrent_th};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // Address phase: capture write target, fetch read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
        end else if (clk_en) begin
            wr_pend_q <= addr_ok && hwrite && (hsize == 3'h2);
            wr_addr_q <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                hrdata_q <= rd_word;
            end
        end
    end

    // Data phase: store the word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= `RFP_CTRL_RESET;
            spike_q <= `RFP_SPIKE_RESET;
        end else if (clk_en && wr_pend_q) begin
            if (wr_addr_q == `RFP_ADDR_CTRL) begin
                ctrl_q <= {31'h0000_0000, hwdata[`RFP_CTRL_QR_EN]};
            end
            if (wr_addr_q == `RFP_ADDR_SPIKE) begin
                spike_q <= hwdata[CUR_W-1:0];
            end
        end
    end

    assign hrdata      = hrdata_q;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign qr_enable   = ctrl_q[`RFP_CTRL_QR_EN];
    assign spike_limit = spike_q;
endmodule

`default_nettype wire

// ===== rfp_top.sv
// Fault-protection and quick-response logic of a two-phase core-rail controller.
// Comparators and PWM core are outside; their outputs are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
`include "rfp_cfg.svh"

// Summary of operation
// - Large step-up load: stop interleaving, one simultaneous high-side pulse all active phases.
// - Quick-response threshold comes from decoding the first platform setting.
// - Latch over-current only if summed current still exceeds spike limit after delay.
// - Latched over-current turns both gates off on every phase.
// - Per-phase over-current checked on each active phase; single-phase mode checks only in soft-start.
// - Per-phase threshold equals spike limit times setting ratio over phase count.
// - Per-phase over-current trip turns both gates off on every phase.
// - Outside lockout, latch over-voltage when output sense exceeds its threshold.
// - Latched over-voltage, with no shutdown fault, holds low-side on, high-side off on active phases.
// - Over-voltage must persist one microsecond before acting.
// - Latch under-voltage when sense falls 500mV below the reference.
// - Latched under-voltage forces both gates off.
// - Under-voltage must persist three microseconds before latching.
// - Supply below reset threshold: lockout, PWM shut down, all gates off.
// - Supply lockout condition filtered for three microseconds.
module rfp_top
    import rfp_pkg::*;
#(
    parameter int NPH   = 2,
    parameter int CUR_W = 12
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               clk_en,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output var  logic [31:0]        hrdata,
    output var  logic               hreadyout,
    output var  logic               hresp,
    input  wire logic               sense_over_voltage,
    input  wire logic               sense_under_voltage,
    input  wire logic               supply_below_por,
    input  wire logic               quick_response_detect,
    input  wire logic               soft_start_active,
    input  wire logic               phase2_sense_negative,
    input  wire logic [2:0]         platform_setting_one,
    input  wire logic [2:0]         platform_setting_thermal,
    input  wire logic [NPH*CUR_W-1:0] phase_current,
    input  wire logic [NPH-1:0]     pwm_high,
    input  wire logic [NPH-1:0]     pwm_low,
    output var  logic [NPH-1:0]     high_side_gate,
    output var  logic [NPH-1:0]     low_side_gate,
    output var  logic               interleave_suspend,
    output var  logic [7:0]         quick_response_threshold,
    output var  logic               fault_shutdown
);
    localparam int SUM_W = CUR_W + $clog2(NPH + 1);
    localparam int PW    = $clog2(`RFP_QR_PULSE_CYC + 1);
    localparam logic [PW-1:0] QR_LAST = PW'(`RFP_QR_PULSE_CYC - 1);

    logic                   qr_enable;
    logic [CUR_W-1:0]       spike_limit;
    logic [CUR_W:0]         per_phase_overcurrent_th;
    logic [CUR_W+3:0]       spike_prod;
    logic [SUM_W-1:0]       current_sum;
    logic [NPH-1:0]         phase_over;
    logic [NPH-1:0]         phase_active;
    logic                   single_phase;
    logic                   per_phase_overcurrent_check;
    logic                   ov_expired;
    logic                   uv_expired;
    logic                   uvlo_expired;
    logic                   ocp_expired;
    logic                   ocp_latched_q;
    logic                   per_phase_overcurrent_latched_q;
    logic                   ovp_latched_q;
    logic                   uvp_latched_q;
    logic                   lockout;
    logic                   all_off;
    logic                   qr_det_q;
    logic [PW-1:0]          qr_cnt_q;
    rfp_qr_state_t          qr_state_q;
    rfp_qr_state_t          qr_state_d;
    logic [NPH-1:0]         high_gate_d;
    logic [NPH-1:0]         low_gate_d;
    logic [7:0]             qr_th_q;

    rfp_ahb_regs #(
        .CUR_W (CUR_W)
    ) u_regs (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .clk_en      (clk_en),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hrdata      (hrdata),
        .hreadyout   (hreadyout),
        .hresp       (hresp),
        .status      ({lockout, uvp_latched_q, ovp_latched_q, per_phase_overcurrent_latched_q, ocp_latched_q,
                       qr_state_q == QR_PULSE}),
        .per_phase_overcurrent_th    (per_phase_overcurrent_th),
        .qr_th       (qr_th_q),
        .qr_enable   (qr_enable),
        .spike_limit (spike_limit)
    );

    // Tied-high negative sense of phase two selects single-phase operation
    assign single_phase = phase2_sense_negative;
    assign per_phase_overcurrent_check  = !single_phase || soft_start_active;

    // Product carries the ratio in eighths; halve again when two phases run
    assign spike_prod = {4'h0, spike_limit} * {{CUR_W{1'b0}}, rfp_decode_ratio(platform_setting_thermal)};
    assign per_phase_overcurrent_th   = single_phase ? spike_prod[CUR_W+3:`RFP_RATIO_FRAC]
                                     : {1'b0, spike_prod[CUR_W+3:`RFP_RATIO_FRAC+1]};

    always_comb begin
        current_sum = '0;
        for (int i = 0; i < NPH; i++) begin
            current_sum = current_sum + SUM_W'(phase_current[i*CUR_W +: CUR_W]);
        end
    end

    generate
        for (genvar g = 0; g < NPH; g++) begin : g_phase
            assign phase_active[g] = (g == 0) || !single_phase;
            assign phase_over[g]   = phase_active[g] && per_phase_overcurrent_check &&
                                     ({1'b0, phase_current[g*CUR_W +: CUR_W]} > per_phase_overcurrent_th);
        end
    endgenerate

    rfp_fault_filter #(
        .CYCLES (`RFP_OCP_DELAY_CYC)
    ) u_ocp_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_en  (clk_en),
        .cond    (current_sum > SUM_W'(spike_limit)),
        .expired (ocp_expired)
    );

    rfp_fault_filter #(
        .CYCLES (`RFP_OV_FILT_CYC)
    ) u_ov_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_en  (clk_en),
        .cond    (sense_over_voltage && !lockout),
        .expired (ov_expired)
    );

    rfp_fault_filter #(
        .CYCLES (`RFP_UV_FILT_CYC)
    ) u_uv_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_en  (clk_en),
        .cond    (sense_under_voltage),
        .expired (uv_expired)
    );

    rfp_fault_filter #(
        .CYCLES (`RFP_UVLO_FILT_CYC)
    ) u_uvlo_filt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clk_en  (clk_en),
        .cond    (supply_below_por),
        .expired (uvlo_expired)
    );

    // Lockout is not latched: PWM restarts once the supply recovers
    assign lockout = uvlo_expired;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ocp_latched_q   <= 1'b0;
            per_phase_overcurrent_latched_q <= 1'b0;
            ovp_latched_q   <= 1'b0;
            uvp_latched_q   <= 1'b0;
        end else if (clk_en) begin
            ocp_latched_q   <= ocp_latched_q || ocp_expired;
            per_phase_overcurrent_latched_q <= per_phase_overcurrent_latched_q || |phase_over;
            ovp_latched_q   <= ovp_latched_q || ov_expired;
            uvp_latched_q   <= uvp_latched_q || uv_expired;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qr_th_q <= 8'h00;
        end else if (clk_en) begin
            qr_th_q <= rfp_decode_qr(platform_setting_one);
        end
    end

    assign all_off = lockout || ocp_latched_q || per_phase_overcurrent_latched_q || uvp_latched_q;

    // One pulse per detector assertion; re-arms only after it drops
    always_comb begin
        qr_state_d = qr_state_q;
        case (qr_state_q)
            QR_IDLE: begin
                if (quick_response_detect && !qr_det_q && qr_enable && !all_off && !ovp_latched_q) begin
                    qr_state_d = QR_PULSE;
                end
            end
            QR_PULSE: begin
                if (qr_cnt_q == QR_LAST || all_off || ovp_latched_q) begin
                    qr_state_d = QR_WAIT;
                end
            end
            QR_WAIT: begin
                if (!quick_response_detect) begin
                    qr_state_d = QR_IDLE;
                end
            end
            default: qr_state_d = QR_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qr_state_q <= QR_IDLE;
            qr_det_q   <= 1'b0;
            qr_cnt_q   <= '0;
        end else if (clk_en) begin
            qr_state_q <= qr_state_d;
            qr_det_q   <= quick_response_detect;
            qr_cnt_q   <= (qr_state_q == QR_PULSE) ? qr_cnt_q + PW'(1) : '0;
        end
    end

    // Gate priority: shutdown, then over-voltage clamp, then pulse, then PWM
    always_comb begin
        high_gate_d = pwm_high & phase_active;
        low_gate_d  = pwm_low & phase_active;
        if (all_off) begin
            high_gate_d = '0;
            low_gate_d  = '0;
        end else if (ovp_latched_q) begin
            high_gate_d = '0;
            low_gate_d  = phase_active;
        end else if (qr_state_d == QR_PULSE) begin
            high_gate_d = phase_active;
            low_gate_d  = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_side_gate <= '0;
            low_side_gate  <= '0;
        end else if (clk_en) begin
            high_side_gate <= high_gate_d;
            low_side_gate  <= low_gate_d;
        end
    end

    assign interleave_suspend       = (qr_state_q == QR_PULSE);
    assign quick_response_threshold = qr_th_q;
    assign fault_shutdown           = all_off || ovp_latched_q;

    sequence ov_held_s;
        (sense_over_voltage && clk_en && !lockout)[*8];
    endsequence

    sequence uv_held_s;
        (sense_under_voltage && clk_en)[*8];
    endsequence

    AST_OCP_GATES_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (ocp_latched_q && clk_en) |=> (high_side_gate == '0 && low_side_gate == '0))
        else $error("gates not off after over-current latch");

    AST_PER_PHASE_OVERCURRENT_GATES_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (per_phase_overcurrent_latched_q && clk_en) |=> (high_side_gate == '0 && low_side_gate == '0))
        else $error("gates not off after per-phase trip");

    AST_OVP_CLAMP: assert property (@(posedge hclk) disable iff (!hresetn)
        (ovp_latched_q && !all_off && clk_en) |=> (high_side_gate == '0 && low_side_gate == phase_active))
        else $error("over-voltage clamp not applied");

    AST_OV_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ovp_latched_q && !sense_over_voltage) ##1 ov_held_s |-> !ovp_latched_q)
        else $error("over-voltage latched before filter time");

    AST_UV_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
        (!uvp_latched_q && !sense_under_voltage) ##1 uv_held_s |-> !uvp_latched_q)
        else $error("under-voltage latched before filter time");

    AST_UVLO_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        (lockout && clk_en) |=> (high_side_gate == '0 && low_side_gate == '0))
        else $error("gates driven during lockout");

    AST_UVLO_FILTER: assert property (@(posedge hclk) disable iff (!hresetn)
        !supply_below_por ##1 (supply_below_por && clk_en)[*8] |-> !lockout)
        else $error("lockout before filter time");

    AST_LATCH_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (ocp_latched_q || ovp_latched_q || uvp_latched_q || per_phase_overcurrent_latched_q) |=>
        (ocp_latched_q || ovp_latched_q || uvp_latched_q || per_phase_overcurrent_latched_q))
        else $error("latched fault released without reset");

    AST_QR_PULSE: assert property (@(posedge hclk) disable iff (!hresetn)
        (qr_state_q == QR_IDLE && qr_state_d == QR_PULSE && clk_en) |=>
        (high_side_gate == phase_active && low_side_gate == '0 && interleave_suspend))
        else $error("quick-response pulse not simultaneous");

    AST_PER_PHASE_OVERCURRENT_SINGLE: assert property (@(posedge hclk) disable iff (!hresetn)
        (single_phase && !soft_start_active) |-> (phase_over == '0))
        else $error("per-phase check outside soft-start in single-phase mode");

    AST_UV_LATCH: assert property (@(posedge hclk) disable iff (!hresetn)
        (uv_expired && clk_en) ##1 clk_en |-> uvp_latched_q ##1 (high_side_gate == '0 && low_side_gate == '0))
        else $error("under-voltage not latched or gates on");
endmodule

`default_nettype wire

// ===== rfp_far_side.sv
// Far-side model: PWM core gate requests and a shoot-through watch on the legs.
// Assumes gate commands are synchronous to hclk and two phases.
`timescale 1ns/1ps
`default_nettype none

module rfp_far_side (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [1:0] high_side_gate,
    input  wire logic [1:0] low_side_gate,
    output var  logic [1:0] pwm_high,
    output var  logic [1:0] pwm_low,
    output var  logic [7:0] shoot_q
);
    logic [2:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q   <= 3'h0;
            shoot_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 3'h1;
            // Both switches of one leg on would short the input rail
            if ((high_side_gate & low_side_gate) != 2'b00) begin
                shoot_q <= shoot_q + 8'h01;
            end
        end
    end

    // Phases interleaved by half a period, never both requests of a leg
    assign pwm_high = {~cnt_q[2], cnt_q[2]};
    assign pwm_low  = ~pwm_high;
endmodule

`default_nettype wire

// ===== regulator_fault_protection_test.sv
// Self-checking bench of the fault-protection block over its AHB-Lite registers.
// Assumes rfp_cfg.svh on the include path and the far-side model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "rfp_cfg.svh"

module regulator_fault_protection_test;
    logic        hclk, hresetn, clk_en, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, pwm_high, pwm_low, high_side_gate, low_side_gate;
    logic [2:0]  hsize, platform_setting_one, platform_setting_thermal;
    logic        sense_over_voltage, sense_under_voltage, supply_below_por;
    logic        quick_response_detect, soft_start_active, phase2_sense_negative;
    logic        interleave_suspend, fault_shutdown;
    logic [23:0] phase_current;
    logic [7:0]  quick_response_threshold, shoot;
    wire         hready;
    int          n_mismatch, tests_run, cycles;
    logic [31:0] rd;
    int          fc[3] = '{`RFP_OV_FILT_CYC, `RFP_UV_FILT_CYC, `RFP_UVLO_FILT_CYC};
    logic [31:0] fs[3] = '{32'h08, 32'h10, 32'h20};
    logic [31:0] fg[3] = '{32'h13, 32'h10, 32'h10};

    assign hready = hreadyout;

    rfp_top u_dut (
        .hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .sense_over_voltage, .sense_under_voltage, .supply_below_por,
        .quick_response_detect, .soft_start_active, .phase2_sense_negative, .platform_setting_one,
        .platform_setting_thermal, .phase_current, .pwm_high, .pwm_low, .high_side_gate,
        .low_side_gate, .interleave_suspend, .quick_response_threshold, .fault_shutdown
    );

    rfp_far_side u_far (
        .hclk, .hresetn, .high_side_gate, .low_side_gate, .pwm_high, .pwm_low, .shoot_q(shoot)
    );

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs about 2600 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        chk(rd & m, e);
    endtask

    task automatic st(input logic [31:0] e);
        rdc(`RFP_ADDR_STATUS, 32'h3F, e);
    endtask

    task automatic gates(input logic [31:0] e);
        // Read one edge later so stimulus stays on the clock edge
        @(posedge hclk);
        chk({27'h0, fault_shutdown, high_side_gate, low_side_gate}, e);
    endtask

    task automatic rst();
        hresetn <= 1'b0;
        phase_current <= 24'h0;
        cyc(5);
        hresetn <= 1'b1;
    endtask

    task automatic drv(input int k, input logic v);
        case (k)
            0: sense_over_voltage <= v;
            1: sense_under_voltage <= v;
            default: supply_below_por <= v;
        endcase
    endtask

    initial begin
        {hresetn, hsel, hwrite, sense_over_voltage, sense_under_voltage, supply_below_por} = 6'h0;
        {quick_response_detect, soft_start_active, phase2_sense_negative} = 3'h0;
        {haddr, hwdata, htrans, hsize, phase_current} = 93'h0;
        {platform_setting_one, platform_setting_thermal} = 6'h03;
        clk_en = 1'b1;
        rst();
        rdc(`RFP_ADDR_CTRL, 32'h1, 32'h1);
        rdc(`RFP_ADDR_SPIKE, 32'hFFF, 32'hC00);
        rdc(32'h10, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 8; i++) begin
            platform_setting_one <= i[2:0];
            cyc(2);
            chk({24'h0, quick_response_threshold}, 32'h18 + 32'h0C * i);
        end
        rdc(`RFP_ADDR_THRESH, 32'h00FF0000, 32'h006C0000);
        // Quick response: all high sides together, interleave stopped
        quick_response_detect <= 1'b1;
        cyc(2);
        gates(32'h0C);
        chk({31'h0, interleave_suspend}, 32'h1);
        cyc(`RFP_QR_PULSE_CYC + 3);
        chk({31'h0, interleave_suspend}, 32'h0);
        quick_response_detect <= 1'b0;
        bus(1'b1, `RFP_ADDR_CTRL, 32'h0);
        quick_response_detect <= 1'b1;
        cyc(3);
        chk({31'h0, interleave_suspend}, 32'h0);
        quick_response_detect <= 1'b0;
        // Per-phase limit in two-phase, then single-phase mode
        rst();
        bus(1'b1, `RFP_ADDR_SPIKE, 32'h100);
        rdc(`RFP_ADDR_THRESH, 32'h1FFF, 32'h0B0);
        phase_current <= {12'h0B1, 12'h000};
        cyc(4);
        st(32'h04);
        gates(32'h10);
        rst();
        bus(1'b1, `RFP_ADDR_SPIKE, 32'h100);
        phase2_sense_negative <= 1'b1;
        rdc(`RFP_ADDR_THRESH, 32'h1FFF, 32'h160);
        phase_current <= {12'h000, 12'h161};
        cyc(4);
        st(32'h0);
        soft_start_active <= 1'b1;
        cyc(4);
        st(32'h04);
        soft_start_active <= 1'b0;
        phase2_sense_negative <= 1'b0;
        // Summed over-current: a drop just before the delay ends restarts it
        rst();
        phase_current <= {12'h700, 12'h700};
        cyc(`RFP_OCP_DELAY_CYC);
        phase_current <= 24'h0;
        cyc(3);
        st(32'h0);
        phase_current <= {12'h700, 12'h700};
        cyc(`RFP_OCP_DELAY_CYC + 3);
        phase_current <= 24'h0;
        st(32'h02);
        gates(32'h10);
        // Frozen clock enable must not let a filter run
        rst();
        clk_en <= 1'b0;
        sense_over_voltage <= 1'b1;
        cyc(`RFP_OV_FILT_CYC + 20);
        sense_over_voltage <= 1'b0;
        clk_en <= 1'b1;
        st(32'h0);
        for (int k = 0; k < 3; k++) begin
            rst();
            drv(k, 1'b1);
            cyc(fc[k]);
            drv(k, 1'b0);
            cyc(3);
            st(32'h0);
            drv(k, 1'b1);
            cyc(fc[k] + 3);
            st(fs[k]);
            gates(fg[k]);
            drv(k, 1'b0);
            cyc(3);
            st(k == 2 ? 32'h0 : fs[k]);
        end
        chk({24'h0, shoot}, 32'h0);
        stop_test();
    end
endmodule

`default_nettype wire
